/* File: design/lbie_pkg.sv */
// constants, operation codes and widths for the logic and branch executor
// assumes a byte-wide data path and a 16-bit program counter
package lbie_pkg;

	// widths
	localparam int DATA_W = 8;
	localparam int PC_W   = 16;
	localparam int DEST_W = 14;
	localparam int ADDR_W = 8;
	localparam int BIT_W  = 3;
	localparam int PAGE_W = 2;
	localparam int BANK_W = 1;

	// operands at or above this address in bank 0 are system registers
	localparam logic [ADDR_W-1:0] SYSREG_BASE = 8'h80;
	localparam logic [BANK_W-1:0] BANK_ZERO   = 1'h0;

	// reset values
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST   = 16'h0000;
	localparam logic              FLAG_RST = 1'h0;

	// program counter steps
	localparam logic [PC_W-1:0] PC_STEP      = 16'h0001;
	localparam logic [PC_W-1:0] PC_SKIP_STEP = 16'h0002;

	// extra cycles beyond the first; counter values
	localparam logic [1:0] CYC_NONE = 2'h0;
	localparam logic [1:0] CYC_ONE  = 2'h1;

	localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

	typedef enum logic [5:0] {
		sub_imm_op,
		and_to_acc,
		and_to_memory,
		and_imm_op,
		or_to_acc,
		or_to_memory,
		or_imm_op,
		xor_to_acc,
		xor_to_memory,
		xor_imm_op,
		nibble_swap_to_acc,
		nibble_swap_to_memory,
		rotate_right_carry_to_acc,
		rotate_right_carry_to_memory,
		rotate_left_carry_to_acc,
		rotate_left_carry_to_memory,
		clear_memory_op,
		bit_clear_op,
		bit_set_op,
		bank_zero_bit_clear_op,
		bank_zero_bit_set_op,
		compare_imm_skip_op,
		compare_skip_op,
		increment_skip_to_acc,
		increment_skip_to_memory,
		decrement_skip_to_acc,
		decrement_skip_to_memory,
		skip_if_bit_zero,
		skip_if_bit_one,
		bank_zero_skip_if_bit_zero,
		bank_zero_skip_if_bit_one,
		jump_op,
		call_op,
		return_op,
		no_op
	} lbie_op_t;

endpackage : lbie_pkg

/* File: design/lbie_alu_if.sv */
// operand and result bundle between the executor and its datapath
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface lbie_alu_if;
	lbie_pkg::lbie_op_t          op;
	logic [lbie_pkg::DATA_W-1:0] acc;
	logic [lbie_pkg::DATA_W-1:0] opnd;
	logic [lbie_pkg::DATA_W-1:0] imm;
	logic [lbie_pkg::BIT_W-1:0]  bit_idx;
	logic                        carry_in;
	logic [lbie_pkg::DATA_W-1:0] res;
	logic                        carry_out;
	logic                        dc_out;
	logic                        zero_out;
	logic                        upd_c;
	logic                        upd_dc;
	logic                        upd_z;
	logic                        to_acc;
	logic                        to_mem;
	logic                        cond;
	logic                        mem_term;
	logic                        bank0;
	logic                        long_op;

	modport core (
		output op, acc, opnd, imm, bit_idx, carry_in,
		input  res, carry_out, dc_out, zero_out, upd_c, upd_dc, upd_z,
		input  to_acc, to_mem, cond, mem_term, bank0, long_op
	);
	modport alu (
		input  op, acc, opnd, imm, bit_idx, carry_in,
		output res, carry_out, dc_out, zero_out, upd_c, upd_dc, upd_z,
		output to_acc, to_mem, cond, mem_term, bank0, long_op
	);
endinterface : lbie_alu_if
`default_nettype wire

/* File: design/lbie_alu.sv */
// combinational datapath: result, flags, target and skip condition
// assumes operands are stable for the whole accepting cycle
`timescale 1ns/1ns
`default_nettype none
module lbie_alu (
	// datapath bundle
	lbie_alu_if.alu a
);

	function automatic logic [7:0] lbie_mask(input logic [2:0] idx);
		return 8'h01 << idx;
	endfunction : lbie_mask

	logic [8:0] diff;
	logic [4:0] hdiff;
	logic [7:0] src;
	logic [7:0] mask;
	logic       bit_val;

	always_comb begin
		src = (a.op inside {lbie_pkg::sub_imm_op, lbie_pkg::and_imm_op,
			lbie_pkg::or_imm_op, lbie_pkg::xor_imm_op,
			lbie_pkg::compare_imm_skip_op}) ? a.imm : a.opnd;
		diff    = {1'b0, a.acc} - {1'b0, src};
		hdiff   = {1'b0, a.acc[3:0]} - {1'b0, src[3:0]};
		mask    = lbie_mask(a.bit_idx);
		bit_val = (a.opnd & mask) != lbie_pkg::BYTE_ZERO;
		a.res       = a.acc;
		a.carry_out = a.carry_in;
		a.dc_out    = 1'b0;
		a.upd_c     = 1'b0;
		a.upd_dc    = 1'b0;
		a.upd_z     = 1'b0;
		a.to_acc    = 1'b0;
		a.to_mem    = 1'b0;
		a.cond      = 1'b0;
		a.mem_term  = 1'b0;
		a.bank0     = 1'b0;
		a.long_op   = 1'b0;
		unique case (a.op)
			// no borrow gives carry 1
			lbie_pkg::sub_imm_op: begin
				a.res       = diff[7:0];
				a.carry_out = ~diff[8];
				a.dc_out    = ~hdiff[4];
				{a.upd_c, a.upd_dc, a.upd_z, a.to_acc} = 4'hf;
			end
			lbie_pkg::and_to_acc, lbie_pkg::and_imm_op,
			lbie_pkg::and_to_memory: begin
				a.res      = a.acc & src;
				a.upd_z    = 1'b1;
				a.to_mem   = a.op == lbie_pkg::and_to_memory;
				a.to_acc   = !a.to_mem;
				a.mem_term = a.to_mem;
			end
			lbie_pkg::or_to_acc, lbie_pkg::or_imm_op,
			lbie_pkg::or_to_memory: begin
				a.res      = a.acc | src;
				a.upd_z    = 1'b1;
				a.to_mem   = a.op == lbie_pkg::or_to_memory;
				a.to_acc   = !a.to_mem;
				a.mem_term = a.to_mem;
			end
			lbie_pkg::xor_to_acc, lbie_pkg::xor_imm_op,
			lbie_pkg::xor_to_memory: begin
				a.res      = a.acc ^ src;
				a.upd_z    = 1'b1;
				a.to_mem   = a.op == lbie_pkg::xor_to_memory;
				a.to_acc   = !a.to_mem;
				a.mem_term = a.to_mem;
			end
			lbie_pkg::nibble_swap_to_acc, lbie_pkg::nibble_swap_to_memory: begin
				a.res      = {a.opnd[3:0], a.opnd[7:4]};
				a.to_mem   = a.op == lbie_pkg::nibble_swap_to_memory;
				a.to_acc   = !a.to_mem;
				a.mem_term = a.to_mem;
			end
			lbie_pkg::rotate_right_carry_to_acc,
			lbie_pkg::rotate_right_carry_to_memory: begin
				a.res       = {a.carry_in, a.opnd[7:1]};
				a.carry_out = a.opnd[0];
				a.upd_c     = 1'b1;
				a.to_mem    = a.op == lbie_pkg::rotate_right_carry_to_memory;
				a.to_acc    = !a.to_mem;
				a.mem_term  = a.to_mem;
			end
			lbie_pkg::rotate_left_carry_to_acc,
			lbie_pkg::rotate_left_carry_to_memory: begin
				a.res       = {a.opnd[6:0], a.carry_in};
				a.carry_out = a.opnd[7];
				a.upd_c     = 1'b1;
				a.to_mem    = a.op == lbie_pkg::rotate_left_carry_to_memory;
				a.to_acc    = !a.to_mem;
				a.mem_term  = a.to_mem;
			end
			lbie_pkg::clear_memory_op: begin
				a.res    = lbie_pkg::BYTE_ZERO;
				a.to_mem = 1'b1;
			end
			lbie_pkg::bit_clear_op, lbie_pkg::bank_zero_bit_clear_op: begin
				a.res      = a.opnd & ~mask;
				a.to_mem   = 1'b1;
				a.mem_term = 1'b1;
				a.bank0    = a.op == lbie_pkg::bank_zero_bit_clear_op;
			end
			lbie_pkg::bit_set_op, lbie_pkg::bank_zero_bit_set_op: begin
				a.res      = a.opnd | mask;
				a.to_mem   = 1'b1;
				a.mem_term = 1'b1;
				a.bank0    = a.op == lbie_pkg::bank_zero_bit_set_op;
			end
			lbie_pkg::compare_imm_skip_op, lbie_pkg::compare_skip_op: begin
				a.res       = diff[7:0];
				a.carry_out = ~diff[8];
				a.upd_c     = 1'b1;
				a.upd_z     = 1'b1;
				a.cond      = diff[7:0] == lbie_pkg::BYTE_ZERO;
			end
			lbie_pkg::increment_skip_to_acc,
			lbie_pkg::increment_skip_to_memory: begin
				a.res      = a.opnd + lbie_pkg::BYTE_ONE;
				a.to_mem   = a.op == lbie_pkg::increment_skip_to_memory;
				a.to_acc   = !a.to_mem;
				a.mem_term = a.to_mem;
				a.cond     = a.res == lbie_pkg::BYTE_ZERO;
			end
			lbie_pkg::decrement_skip_to_acc,
			lbie_pkg::decrement_skip_to_memory: begin
				a.res      = a.opnd - lbie_pkg::BYTE_ONE;
				a.to_mem   = a.op == lbie_pkg::decrement_skip_to_memory;
				a.to_acc   = !a.to_mem;
				a.mem_term = a.to_mem;
				a.cond     = a.res == lbie_pkg::BYTE_ZERO;
			end
			lbie_pkg::skip_if_bit_zero, lbie_pkg::bank_zero_skip_if_bit_zero: begin
				a.cond  = !bit_val;
				a.bank0 = a.op == lbie_pkg::bank_zero_skip_if_bit_zero;
			end
			lbie_pkg::skip_if_bit_one, lbie_pkg::bank_zero_skip_if_bit_one: begin
				a.cond  = bit_val;
				a.bank0 = a.op == lbie_pkg::bank_zero_skip_if_bit_one;
			end
			lbie_pkg::jump_op, lbie_pkg::call_op, lbie_pkg::return_op,
			lbie_pkg::no_op: begin
				a.long_op = 1'b1;
			end
			default: begin
				a.res = a.acc;
			end
		endcase
		a.zero_out = a.res == lbie_pkg::BYTE_ZERO;
	end

endmodule : lbie_alu
`default_nettype wire

/* File: design/lbie_exec.sv */
// executor for logic, rotate, bit, skip and branch operations
// assumes fetch presents a decoded op with its operand byte already read,
// and that data memory takes one write strobe per accepted op
`timescale 1ns/1ns
`default_nettype none
// Contract
// - subtract immediate from accumulator; carry cleared on borrow, set otherwise.
// - and, or, xor to accumulator, to memory, or with immediate.
// - nibble swap loads accumulator, or stores swapped byte back to memory.
// - bit clear and set force one memory bit; bank-zero forms exist.
// - compare updates zero and carry, keeps accumulator, skips when equal.
// - increment or decrement memory into accumulator, skip when result zero.
// - memory forms write back, skip on zero, take one plus N plus S.
// - bit tests skip on selected bit zero or one, flags untouched.
// - jump loads low fourteen bits from op, top two from page bits.
// - call pushes program counter plus one then jumps; return pops; two cycles each.
// - memory term costs nothing for system registers, one cycle for RAM.
// - skip operations take one extra cycle when their condition holds.
module lbie_exec #(
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_i,
	// decoded operation from fetch
	input  wire logic                          instr_valid_i,
	input  wire lbie_pkg::lbie_op_t            instr_op_i,
	input  wire logic [lbie_pkg::ADDR_W-1:0]   instr_addr_i,
	input  wire logic [lbie_pkg::BIT_W-1:0]    instr_bit_i,
	input  wire logic [lbie_pkg::DATA_W-1:0]   instr_imm_i,
	input  wire logic [lbie_pkg::DEST_W-1:0]   instr_dest_i,
	output logic                               ready_o,
	output logic                               skip_o,
	// data memory
	input  wire logic [lbie_pkg::DATA_W-1:0]   mem_rdata_i,
	input  wire logic [lbie_pkg::BANK_W-1:0]   bank_i,
	output logic                               mem_we_o,
	output logic [lbie_pkg::BANK_W+lbie_pkg::ADDR_W-1:0] mem_addr_o,
	output logic [lbie_pkg::DATA_W-1:0]        mem_wdata_o,
	// system state
	input  wire logic [lbie_pkg::PAGE_W-1:0]   rom_page_select_bits_i,
	output logic [lbie_pkg::DATA_W-1:0]        acc_o,
	output logic                               carry_o,
	output logic                               dc_o,
	output logic                               zero_flag_o,
	output logic [lbie_pkg::PC_W-1:0]          pc_o
);

	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);
	localparam logic [SP_W-1:0] SP_ZERO = '0;

	if (STACK_DEPTH < 2 || STACK_DEPTH > 16 ||
		(STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("stack depth must be a power of two from 2 to 16");
	end

	typedef struct packed {
		logic [lbie_pkg::DATA_W-1:0]                  acc;
		logic                                         carry;
		logic                                         dc;
		logic                                         zero;
		logic [lbie_pkg::PC_W-1:0]                    pc;
		logic [SP_W-1:0]                              sp;
		logic [STACK_DEPTH-1:0][lbie_pkg::PC_W-1:0]   stack;
		logic [1:0]                                   wait_cnt;
		logic                                         ready;
		logic                                         skip;
		logic                                         we;
		logic [lbie_pkg::BANK_W+lbie_pkg::ADDR_W-1:0] waddr;
		logic [lbie_pkg::DATA_W-1:0]                  wdata;
	} lbie_state_t;

	lbie_state_t st_reg;
	lbie_state_t st_next;

	logic                        accept;
	logic [lbie_pkg::BANK_W-1:0] eff_bank;
	logic                        is_sys;
	logic                        n_term;
	logic [1:0]                  extra;

	lbie_alu_if alu_bus ();

	lbie_alu u_alu (
		.a (alu_bus)
	);

	assign alu_bus.op       = instr_op_i;
	assign alu_bus.acc      = st_reg.acc;
	assign alu_bus.opnd     = mem_rdata_i;
	assign alu_bus.imm      = instr_imm_i;
	assign alu_bus.bit_idx  = instr_bit_i;
	assign alu_bus.carry_in = st_reg.carry;

	assign accept = instr_valid_i && st_reg.ready;

	// bank-zero forms ignore the current bank
	assign eff_bank = alu_bus.bank0 ? lbie_pkg::BANK_ZERO : bank_i;
	assign is_sys   = eff_bank == lbie_pkg::BANK_ZERO &&
		instr_addr_i >= lbie_pkg::SYSREG_BASE;
	assign n_term   = alu_bus.mem_term && !is_sys;
	// cycles after the first: N plus S, or one for jump, call, return and no_op
	assign extra    = {1'b0, alu_bus.long_op} + {1'b0, n_term} +
		{1'b0, alu_bus.cond};

	always_comb begin
		st_next      = st_reg;
		st_next.skip = 1'b0;
		st_next.we   = 1'b0;
		if (st_reg.wait_cnt != lbie_pkg::CYC_NONE) begin
			st_next.wait_cnt = st_reg.wait_cnt - lbie_pkg::CYC_ONE;
			st_next.ready    = st_reg.wait_cnt == lbie_pkg::CYC_ONE;
		end else if (accept) begin
			st_next.wait_cnt = extra;
			st_next.ready    = extra == lbie_pkg::CYC_NONE;
			if (alu_bus.to_acc) begin
				st_next.acc = alu_bus.res;
			end
			if (alu_bus.upd_c) begin
				st_next.carry = alu_bus.carry_out;
			end
			if (alu_bus.upd_dc) begin
				st_next.dc = alu_bus.dc_out;
			end
			if (alu_bus.upd_z) begin
				st_next.zero = alu_bus.zero_out;
			end
			if (alu_bus.to_mem) begin
				st_next.we    = 1'b1;
				st_next.waddr = {eff_bank, instr_addr_i};
				st_next.wdata = alu_bus.res;
			end
			if (instr_op_i == lbie_pkg::jump_op) begin
				st_next.pc = {rom_page_select_bits_i, instr_dest_i};
			end else if (instr_op_i == lbie_pkg::call_op) begin
				// return address is the op after the call
				st_next.stack[st_reg.sp] = st_reg.pc + lbie_pkg::PC_STEP;
				st_next.sp = st_reg.sp + SP_ONE;
				st_next.pc = {rom_page_select_bits_i, instr_dest_i};
			end else if (instr_op_i == lbie_pkg::return_op) begin
				st_next.sp = st_reg.sp - SP_ONE;
				st_next.pc = st_reg.stack[st_reg.sp - SP_ONE];
			end else if (alu_bus.cond) begin
				st_next.pc   = st_reg.pc + lbie_pkg::PC_SKIP_STEP;
				st_next.skip = 1'b1;
			end else begin
				st_next.pc = st_reg.pc + lbie_pkg::PC_STEP;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_reg.acc      <= lbie_pkg::ACC_RST;
			st_reg.carry    <= lbie_pkg::FLAG_RST;
			st_reg.dc       <= lbie_pkg::FLAG_RST;
			st_reg.zero     <= lbie_pkg::FLAG_RST;
			st_reg.pc       <= lbie_pkg::PC_RST;
			st_reg.sp       <= SP_ZERO;
			st_reg.stack    <= '0;
			st_reg.wait_cnt <= lbie_pkg::CYC_NONE;
			st_reg.ready    <= 1'b1;
			st_reg.skip     <= 1'b0;
			st_reg.we       <= 1'b0;
			st_reg.waddr    <= '0;
			st_reg.wdata    <= lbie_pkg::BYTE_ZERO;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ready_o     = st_reg.ready;
	assign skip_o      = st_reg.skip;
	assign mem_we_o    = st_reg.we;
	assign mem_addr_o  = st_reg.waddr;
	assign mem_wdata_o = st_reg.wdata;
	assign acc_o       = st_reg.acc;
	assign carry_o     = st_reg.carry;
	assign dc_o        = st_reg.dc;
	assign zero_flag_o = st_reg.zero;
	assign pc_o        = st_reg.pc;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	a_sub_result: assert property (
		accept && instr_op_i == lbie_pkg::sub_imm_op |=>
		acc_o == 8'($past(acc_o) - $past(instr_imm_i)) &&
		carry_o == ($past(acc_o) >= $past(instr_imm_i)))
		else $error("subtract result or carry wrong");

	a_logic_writeback: assert property (
		accept && instr_op_i == lbie_pkg::and_to_memory |=>
		mem_we_o && mem_wdata_o == ($past(acc_o) & $past(mem_rdata_i)) &&
		acc_o == $past(acc_o))
		else $error("and write-back wrong");

	a_swap_acc: assert property (
		accept && instr_op_i == lbie_pkg::nibble_swap_to_acc |=>
		acc_o == 8'({$past(mem_rdata_i), $past(mem_rdata_i)} >> 4) && !mem_we_o)
		else $error("nibble swap wrong");

	a_bit_set: assert property (
		accept && instr_op_i == lbie_pkg::bit_set_op |=>
		mem_we_o &&
		mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << $past(instr_bit_i))))
		else $error("bit set wrong");

	a_compare_equal: assert property (
		accept && instr_op_i == lbie_pkg::compare_imm_skip_op &&
		acc_o == instr_imm_i |=>
		skip_o && zero_flag_o && carry_o && acc_o == $past(acc_o) && !ready_o)
		else $error("equal compare did not skip");

	a_inc_acc: assert property (
		accept && instr_op_i == lbie_pkg::increment_skip_to_acc |=>
		acc_o == 8'($past(mem_rdata_i) + 8'h01) && !mem_we_o &&
		skip_o == (acc_o == 8'h00))
		else $error("increment to accumulator wrong");

	a_dec_mem_cycles: assert property (
		accept && instr_op_i == lbie_pkg::decrement_skip_to_memory &&
		mem_rdata_i == 8'h01 && bank_i == 1'h0 &&
		instr_addr_i < lbie_pkg::SYSREG_BASE |=>
		(mem_we_o && mem_wdata_o == 8'h00 && skip_o && !ready_o)
		##1 !ready_o ##1 ready_o)
		else $error("decrement to memory timing wrong");

	a_bit_test_flags: assert property (
		accept && instr_op_i == lbie_pkg::skip_if_bit_one |=>
		skip_o == ((($past(mem_rdata_i) >> $past(instr_bit_i)) & 8'h01)
		!= 8'h00) && carry_o == $past(carry_o) &&
		zero_flag_o == $past(zero_flag_o) && !mem_we_o)
		else $error("bit test wrong");

	a_jump_target: assert property (
		accept && instr_op_i == lbie_pkg::jump_op |=>
		pc_o == {$past(rom_page_select_bits_i), $past(instr_dest_i)} &&
		!ready_o ##1 ready_o)
		else $error("jump target or length wrong");

	a_call_return: assert property (
		accept && instr_op_i == lbie_pkg::call_op ##2
		accept && instr_op_i == lbie_pkg::return_op |=>
		pc_o == 16'($past(pc_o, 3) + 16'h0001))
		else $error("return did not restore the call site");

	a_sysreg_no_wait: assert property (
		accept && instr_op_i == lbie_pkg::or_to_memory && bank_i == 1'h0 &&
		instr_addr_i >= lbie_pkg::SYSREG_BASE |=> ready_o && mem_we_o)
		else $error("system register op took an extra cycle");

	a_no_skip_cost: assert property (
		accept && instr_op_i == lbie_pkg::compare_skip_op &&
		acc_o != mem_rdata_i |=> ready_o && !skip_o)
		else $error("unequal compare cost a cycle");

	a_rotate_left: assert property (
		accept && instr_op_i == lbie_pkg::rotate_left_carry_to_acc |=>
		acc_o == 8'({$past(mem_rdata_i), $past(carry_o)}) &&
		carry_o == ($past(mem_rdata_i) >= 8'h80))
		else $error("rotate through carry wrong");

	a_clear_mem: assert property (
		accept && instr_op_i == lbie_pkg::clear_memory_op |=>
		mem_we_o && mem_wdata_o == 8'h00 && ready_o &&
		carry_o == $past(carry_o) && dc_o == $past(dc_o))
		else $error("clear wrong");

	a_or_imm: assert property (
		accept && instr_op_i == lbie_pkg::or_imm_op |=>
		acc_o == ($past(acc_o) | $past(instr_imm_i)) &&
		zero_flag_o == (acc_o == 8'h00))
		else $error("or with immediate wrong");

	a_swap_mem: assert property (
		accept && instr_op_i == lbie_pkg::nibble_swap_to_memory |=>
		mem_we_o && acc_o == $past(acc_o) &&
		mem_wdata_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
		else $error("nibble swap to memory wrong");

	a_bank_zero_addr: assert property (
		accept && instr_op_i == lbie_pkg::bank_zero_bit_set_op |=>
		mem_we_o &&
		mem_addr_o == {lbie_pkg::BANK_ZERO, $past(instr_addr_i)})
		else $error("bank-zero write went to the wrong bank");

	a_ram_wait: assert property (
		accept && instr_op_i == lbie_pkg::and_to_memory && bank_i == 1'h0 &&
		instr_addr_i < lbie_pkg::SYSREG_BASE |=> !ready_o ##1 ready_o)
		else $error("ram write-back did not take one extra cycle");

	a_skip_advance: assert property (
		skip_o |-> pc_o == 16'($past(pc_o) + 16'h0002) && !ready_o)
		else $error("skip did not step over one op");

	c_call_taken: cover property (
		accept && instr_op_i == lbie_pkg::call_op);
	c_skip_taken: cover property (skip_o && mem_we_o);
	c_three_cycle: cover property (!ready_o ##1 !ready_o ##1 ready_o);
	c_writeback: cover property (mem_we_o && ready_o);
	c_bank_zero: cover property (accept && bank_i == 1'h1 &&
		instr_op_i == lbie_pkg::bank_zero_bit_set_op);

endmodule : lbie_exec
`default_nettype wire

/* File: dv/lbie_ram_model.sv */
// data memory model that answers the executor's operand reads
// assumes one write strobe per accepted op, on the same clock
`timescale 1ns/1ns
`default_nettype none
module lbie_ram_model (
	// clock
	input  wire logic       ref_clk_i,
	// read side, combinational
	input  wire logic [8:0] rd_addr_i,
	output logic      [7:0] rdata_o,
	// write side
	input  wire logic       we_i,
	input  wire logic [8:0] wr_addr_i,
	input  wire logic [7:0] wdata_i
);
	logic [7:0] mem [512];

	assign rdata_o = mem[rd_addr_i];

	always @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[wr_addr_i] <= wdata_i;
		end
	end
endmodule : lbie_ram_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the logic and branch executor
// assumes operand bytes come from the data memory model
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic               ref_clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               vld = 1'b0;
	lbie_pkg::lbie_op_t op = lbie_pkg::no_op;
	logic [7:0]         ad = 8'h00;
	logic [7:0]         imm = 8'h00;
	logic [2:0]         bi = 3'h0;
	logic [13:0]        de = 14'h0000;
	logic               bank = 1'b0;
	logic [1:0]         pg = 2'h0;
	logic               rdy, sk, we, c, dc, z, sk1, rb;
	logic [7:0]         rd, wd, acc;
	logic [8:0]         wa;
	logic [15:0]        pc, epc;
	int                 num_errors = 0;
	int                 checks = 0;
	int                 cyc = 0;
	int                 n;

	// bank-zero ops read bank 0 whatever the current bank
	assign rb = bank && !(op inside {lbie_pkg::bank_zero_bit_clear_op,
		lbie_pkg::bank_zero_bit_set_op, lbie_pkg::bank_zero_skip_if_bit_zero,
		lbie_pkg::bank_zero_skip_if_bit_one});

	lbie_exec dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.instr_valid_i(vld), .instr_op_i(op), .instr_addr_i(ad),
		.instr_bit_i(bi), .instr_imm_i(imm), .instr_dest_i(de),
		.ready_o(rdy), .skip_o(sk), .mem_rdata_i(rd), .bank_i(bank),
		.mem_we_o(we), .mem_addr_o(wa), .mem_wdata_o(wd),
		.rom_page_select_bits_i(pg), .acc_o(acc), .carry_o(c),
		.dc_o(dc), .zero_flag_o(z), .pc_o(pc));
	lbie_ram_model ram (.ref_clk_i(ref_clk_i), .rd_addr_i({rb, ad}),
		.rdata_o(rd), .we_i(we), .wr_addr_i(wa), .wdata_i(wd));

	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// hang guard, far above the sixty or so cycles needed
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			results();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one op: offered at a falling edge, held until taken
	task automatic go(input lbie_pkg::lbie_op_t o, input logic [7:0] a,
		input logic [7:0] i, input logic s, input int cy);
		op = o;
		ad = a;
		imm = i;
		vld = 1'b1;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		sk1 = sk;
		n = 1;
		while (rdy !== 1'b1 && n < 9) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (o != lbie_pkg::jump_op && o != lbie_pkg::call_op &&
			o != lbie_pkg::return_op) begin
			epc = epc + 16'(1 + s);
		end
		chk(pc, epc);
		chk(16'(sk1), 16'(s));
		chk(16'(n), 16'(cy));
	endtask : go

	task automatic t_logic;
		go(lbie_pkg::or_imm_op, 8'h00, 8'h35, 1'b0, 1);
		go(lbie_pkg::sub_imm_op, 8'h00, 8'h36, 1'b0, 1);
		chk(16'(acc), 16'h00ff);
		chk(16'(c), 16'h0000);
		go(lbie_pkg::sub_imm_op, 8'h00, 8'h0f, 1'b0, 1);
		chk(16'({dc, c, acc}), 16'h03f0);
		go(lbie_pkg::xor_imm_op, 8'h00, 8'hff, 1'b0, 1);
		go(lbie_pkg::and_imm_op, 8'h00, 8'h3c, 1'b0, 1);
		chk(16'(acc), 16'h000c);
		ram.mem[9'h010] = 8'hf3;
		go(lbie_pkg::and_to_memory, 8'h10, 8'h00, 1'b0, 2);
		chk(16'({z, acc}), 16'h010c);
		chk(16'(ram.mem[9'h010]), 16'h0000);
		go(lbie_pkg::xor_to_acc, 8'h10, 8'h00, 1'b0, 1);
		go(lbie_pkg::or_to_acc, 8'h10, 8'h00, 1'b0, 1);
		chk(16'(acc), 16'h000c);
		ram.mem[9'h080] = 8'hff;
		go(lbie_pkg::or_to_memory, 8'h80, 8'h00, 1'b0, 1);
		bank = 1'b1;
		ram.mem[9'h180] = 8'h30;
		go(lbie_pkg::xor_to_memory, 8'h80, 8'h00, 1'b0, 2);
		chk(16'(wa), 16'h0180);
		chk(16'(ram.mem[9'h180]), 16'h003c);
		bank = 1'b0;
	endtask : t_logic

	task automatic t_swap_rot;
		ram.mem[9'h020] = 8'h3c;
		go(lbie_pkg::nibble_swap_to_acc, 8'h20, 8'h00, 1'b0, 1);
		chk(16'(acc), 16'h00c3);
		go(lbie_pkg::nibble_swap_to_memory, 8'h20, 8'h00, 1'b0, 2);
		chk(16'(ram.mem[9'h020]), 16'h00c3);
		ram.mem[9'h021] = 8'h81;
		go(lbie_pkg::rotate_right_carry_to_acc, 8'h21, 8'h00, 1'b0, 1);
		chk(16'({c, acc}), 16'h01c0);
		ram.mem[9'h022] = 8'h40;
		go(lbie_pkg::rotate_left_carry_to_memory, 8'h22, 8'h00, 1'b0, 2);
		chk(16'({c, ram.mem[9'h022]}), 16'h0081);
		go(lbie_pkg::rotate_left_carry_to_acc, 8'h22, 8'h00, 1'b0, 1);
		chk(16'({c, acc}), 16'h0102);
		go(lbie_pkg::rotate_right_carry_to_memory, 8'h22, 8'h00, 1'b0, 2);
		chk(16'({c, ram.mem[9'h022]}), 16'h01c0);
	endtask : t_swap_rot

	task automatic t_bits;
		ram.mem[9'h030] = 8'h00;
		ram.mem[9'h031] = 8'hff;
		bi = 3'h5;
		go(lbie_pkg::bit_set_op, 8'h30, 8'h00, 1'b0, 2);
		go(lbie_pkg::bit_clear_op, 8'h31, 8'h00, 1'b0, 2);
		chk({ram.mem[9'h030], ram.mem[9'h031]}, 16'h20df);
		ram.mem[9'h085] = 8'h00;
		ram.mem[9'h032] = 8'hff;
		bi = 3'h0;
		bank = 1'b1;
		go(lbie_pkg::bank_zero_bit_set_op, 8'h85, 8'h00, 1'b0, 1);
		go(lbie_pkg::bank_zero_bit_clear_op, 8'h32, 8'h00, 1'b0, 2);
		bank = 1'b0;
		chk({ram.mem[9'h085], ram.mem[9'h032]}, 16'h01fe);
		go(lbie_pkg::clear_memory_op, 8'h30, 8'h00, 1'b0, 1);
		chk(16'({c, we, wd}), 16'h0300);
	endtask : t_bits

	task automatic t_skips;
		ram.mem[9'h031] = 8'hc1;
		ram.mem[9'h032] = 8'hff;
		ram.mem[9'h033] = 8'h01;
		ram.mem[9'h034] = 8'h02;
		go(lbie_pkg::compare_imm_skip_op, 8'h00, 8'h02, 1'b1, 2);
		chk(16'({z, c, acc}), 16'h0302);
		go(lbie_pkg::compare_skip_op, 8'h31, 8'h00, 1'b0, 1);
		chk(16'({z, c, acc}), 16'h0002);
		go(lbie_pkg::increment_skip_to_memory, 8'h32, 8'h00, 1'b1, 3);
		chk(16'(ram.mem[9'h032]), 16'h0000);
		go(lbie_pkg::decrement_skip_to_memory, 8'h34, 8'h00, 1'b0, 2);
		chk(16'(ram.mem[9'h034]), 16'h0001);
		go(lbie_pkg::decrement_skip_to_memory, 8'h34, 8'h00, 1'b1, 3);
		chk(16'(ram.mem[9'h034]), 16'h0000);
		go(lbie_pkg::decrement_skip_to_acc, 8'h33, 8'h00, 1'b1, 2);
		chk({acc, ram.mem[9'h033]}, 16'h0001);
		go(lbie_pkg::increment_skip_to_acc, 8'h33, 8'h00, 1'b0, 1);
		chk(16'(acc), 16'h0002);
		bi = 3'h7;
		go(lbie_pkg::skip_if_bit_one, 8'h31, 8'h00, 1'b1, 2);
		go(lbie_pkg::skip_if_bit_zero, 8'h31, 8'h00, 1'b0, 1);
		bi = 3'h1;
		go(lbie_pkg::bank_zero_skip_if_bit_zero, 8'h31, 8'h00, 1'b1, 2);
		go(lbie_pkg::bank_zero_skip_if_bit_one, 8'h31, 8'h00, 1'b0, 1);
		chk(16'({z, c}), 16'h0000);
	endtask : t_skips

	task automatic t_branch;
		pg = 2'h2;
		de = 14'h1234;
		epc = 16'h9234;
		go(lbie_pkg::jump_op, 8'h00, 8'h00, 1'b0, 2);
		go(lbie_pkg::no_op, 8'h00, 8'h00, 1'b0, 2);
		pg = 2'h1;
		de = 14'h0100;
		epc = 16'h4100;
		go(lbie_pkg::call_op, 8'h00, 8'h00, 1'b0, 2);
		epc = 16'h9236;
		go(lbie_pkg::return_op, 8'h00, 8'h00, 1'b0, 2);
	endtask : t_branch

	task automatic results;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		repeat (2) @(negedge ref_clk_i);
		rst_i = 1'b0;
		epc = 16'h0000;
		chk({acc, 7'h00, c}, 16'h0000);
		t_logic();
		t_swap_rot();
		t_bits();
		t_skips();
		t_branch();
		results();
	end
endmodule : testbench
`default_nettype wire
